// file: shared/hbp_pkg.sv
// Constants shared by the host bus port design
package hbp_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG_REG_FIFTY = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS       = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK         = 8'h08;
  localparam logic [7:0] OFS_BUS_WATCH_TIMER  = 8'h0c;
  localparam logic [7:0] OFS_RX_IRQ_TIMER     = 8'h10;
  localparam logic [7:0] OFS_RX_IRQ_COUNT     = 8'h14;
  localparam logic [7:0] OFS_RX_TALLY         = 8'h18;
  localparam logic [7:0] OFS_PORT_STATUS      = 8'h1c;
  localparam logic [7:0] OFS_CACHE_DATA       = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_UPPER_ADDR_EN = 6;
  localparam int CFG_MII_MODE      = 0;
  localparam int CFG_DMA_MODE      = 1;
  localparam int CFG_BURST_LSB     = 2;
  localparam int IRQ_RX            = 0;
  localparam int IRQ_BUS_ABORT     = 1;
  localparam int IRQ_WRITE_DONE    = 2;
  localparam int IRQ_BITS          = 3;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  localparam logic [15:0] WATCH_RESET    = 16'h00ff;
  localparam logic [15:0] RX_TIMER_RESET = 16'h0000;
  localparam logic [7:0]  RX_COUNT_RESET = 8'h01;
  localparam logic [1:0]  BURST_X1       = 2'h0;
  localparam logic [1:0]  BURST_X2       = 2'h1;
  localparam logic [1:0]  BURST_X4       = 2'h2;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // Timing and packet memory requester count
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int TICK_NS         = 1000;
  localparam int TICK_CYCLES     = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int SRAM_REQUESTERS = 3;

endpackage : hbp_pkg

// file: hdl/hbp_arbiter.sv
// Round robin grant among packet memory requesters
module hbp_arbiter
  import hbp_pkg::*;
(
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [SRAM_REQUESTERS-1:0] req,
  output logic      [SRAM_REQUESTERS-1:0] grant
);

  typedef struct packed {
    logic [SRAM_REQUESTERS-1:0] grant;
    logic [1:0]                 last;
  } hbp_arb_s;

  hbp_arb_s st, next_st;

  // Rotating priority so no requester starves
  always_comb begin
    logic [1:0] idx;
    idx = 2'h0;
    next_st = st;
    next_st.grant = '0;
    for (int k = 1; k <= SRAM_REQUESTERS; k++) begin
      idx = 2'((int'(st.last) + k) % SRAM_REQUESTERS);
      if (next_st.grant == '0 && req[idx]) begin
        next_st.grant[idx] = 1'b1;
        next_st.last = idx;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign grant = st.grant;

  one_grant_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0(grant)) else $error("more than one memory grant");
  grant_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (req != '0) |=> (grant != '0)) else $error("request not granted");

endmodule : hbp_arbiter

// file: hdl/hbp_host_port.sv
// Host bus port: pins, burst reads, watch timer, receive irq pacing
// Notes on behaviour
// - Width select picks 32 or 16 bit access
// - Upper address bits zero until decode enabled
// - MII mode reuses upper address pins
// - Write done ready rises after data captured
// - Burst reads x1 x2 x4 from cache
// - Two handshake signals for data port
// - Request low asks burst; ack low during
// - Data port or host DMA access
// - Arbiter shares memory among three requesters
// - Watch timer aborts overlong host access
// - Asynchronous 32 bit host bus
// - Receive irq paced by timer and count
// - Access only while chip select low
// - Active low open drain interrupt
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
module hbp_host_port
  import hbp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        host_width_select,
  input  wire logic        chip_select_n,
  input  wire logic        host_rd_n,
  input  wire logic        host_wr_n,
  input  wire logic [15:1] host_addr,
  input  wire logic [31:0] host_data_in,
  output logic      [31:0] host_data_out,
  output logic             host_data_oe,
  output logic             write_done_ready,
  output logic             burst_request_n,
  input  wire logic        burst_ack_n,
  output logic             irq_out_n,
  output logic             irq_out_oe,
  output logic [3:0]       mii_rx,
  input  wire logic        rx_packet_done,
  input  wire logic [31:0] rx_buffer_word,
  input  wire logic        rx_buffer_valid,
  input  wire logic        tx_dma_req,
  input  wire logic        rx_dma_req,
  output logic      [2:0]  sram_grant,
  output logic      [31:0] host_write_word,
  output logic             host_write_strobe
);

  typedef enum logic [1:0] {HS_IDLE, HS_WRITE, HS_READ, HS_END} hbp_host_e;

  typedef struct packed {
    logic [2:0]  rd_s, wr_s, cs_s, ack_s;
    logic [3:0]  a_s1, a_s2, a_s3;
    hbp_host_e   hs;
    logic        aw_seen, w_seen;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        bvalid, rvalid, arready, awrdy, wrdy;
    logic [31:0] rdata;
    logic [1:0]  rresp, bresp;
    logic [31:0] cfg;
    logic [IRQ_BITS-1:0] status, mask;
    logic [15:0] watch_lim, watch_cnt, rx_tim_lim, rx_tim_cnt;
    logic [7:0]  rx_cnt_lim, rx_pend, tally;
    logic [4:0]  tick;
    logic [3:0][31:0] cache;
    logic [2:0]  fill, beat;
    logic [31:0] dout;
    logic        doe, wdr, breq, irq;
    logic [3:0]  mii;
    logic [31:0] wword;
    logic        wstb;
  } hbp_port_s;

  hbp_port_s st, next_st;
  logic [2:0] grant_w;

  hbp_arbiter u_arb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req     ({rx_dma_req, tx_dma_req, st.hs != HS_IDLE}),
    .grant   (grant_w)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rd_a, wr_a, cs_a, ack_a, tick_p, timeout, sel;
    logic [2:0] blen;
    logic [3:0] upper;
    logic [15:1] eff_addr;
    {rd_a, wr_a, cs_a, ack_a, tick_p, timeout, sel} = '0;
    blen     = 3'h1;
    upper    = 4'h0;
    eff_addr = '0;
    next_st = st;
    // Pins from another domain: third stage confirms the second
    next_st.rd_s  = {st.rd_s[1:0], host_rd_n};
    next_st.wr_s  = {st.wr_s[1:0], host_wr_n};
    next_st.cs_s  = {st.cs_s[1:0], chip_select_n};
    next_st.ack_s = {st.ack_s[1:0], burst_ack_n};
    next_st.a_s1  = host_addr[11:8];
    next_st.a_s2  = st.a_s1;
    next_st.a_s3  = st.a_s2;
    rd_a  = (st.rd_s[2:1] == 2'b00);
    wr_a  = (st.wr_s[2:1] == 2'b00);
    cs_a  = (st.cs_s[2:1] == 2'b00);
    ack_a = (st.ack_s[2:1] == 2'b00);
    upper = (st.a_s2 == st.a_s3) ? st.a_s3 : st.mii;
    // Pins double as MII receive inputs in external mode
    if (st.cfg[CFG_MII_MODE]) next_st.mii = upper;
    eff_addr = host_addr;
    if (st.cfg[CFG_MII_MODE] || !st.cfg[CFG_UPPER_ADDR_EN])
      eff_addr[11:8] = 4'h0;
    sel = (eff_addr[15:8] == 8'h00);
    next_st.tick = (st.tick == 5'(TICK_CYCLES - 1)) ? 5'h0 : st.tick + 5'h1;
    tick_p = (st.tick == 5'(TICK_CYCLES - 1));
    case (st.cfg[CFG_BURST_LSB +: 2])
      BURST_X2: blen = 3'h2;
      BURST_X4: blen = 3'h4;
      default:  blen = 3'h1;
    endcase
    next_st.wstb = 1'b0;
    // Cache fills from the receive buffer while no burst is running
    if (rx_buffer_valid && st.fill < blen && st.hs != HS_READ) begin
      next_st.cache[st.fill[1:0]] = rx_buffer_word;
      next_st.fill = st.fill + 3'h1;
    end
    next_st.breq = !(st.fill == blen && st.hs == HS_IDLE
                     && st.cfg[CFG_DMA_MODE]);
    timeout = (st.hs != HS_IDLE) && (st.watch_cnt >= st.watch_lim);
    next_st.watch_cnt = (st.hs == HS_IDLE) ? 16'h0 :
                        (tick_p ? st.watch_cnt + 16'h1 : st.watch_cnt);
    case (st.hs)
      HS_IDLE: begin
        next_st.wdr = 1'b0;
        next_st.doe = 1'b0;
        if (cs_a && sel && wr_a) begin
          next_st.wword = host_width_select ? {16'h0, host_data_in[15:0]}
                                            : host_data_in;
          next_st.wstb = 1'b1;
          next_st.hs = HS_WRITE;
        end else if (cs_a && sel && rd_a && st.fill != 3'h0 &&
                     (ack_a || !st.cfg[CFG_DMA_MODE])) begin
          // Beat kept, so a burst split over strobes resumes in place
          next_st.hs = HS_READ;
        end
      end
      HS_WRITE: begin
        next_st.wdr = 1'b1;
        if (!wr_a || !cs_a) next_st.hs = HS_END;
      end
      HS_READ: begin
        next_st.doe = cs_a;
        next_st.dout = host_width_select ? {16'h0, st.cache[st.beat[1:0]][15:0]}
                                         : st.cache[st.beat[1:0]];
        if (!rd_a || !cs_a || (st.cfg[CFG_DMA_MODE] && !ack_a)) begin
          next_st.beat = st.beat + 3'h1;
          if (st.beat + 3'h1 >= st.fill) begin
            next_st.fill = 3'h0;
            next_st.beat = 3'h0;
            next_st.hs = HS_END;
          end else if (!cs_a) begin
            next_st.hs = HS_END;
          end
        end
      end
      HS_END: begin
        next_st.wdr = 1'b0;
        next_st.doe = 1'b0;
        if (!wr_a && !rd_a) next_st.hs = HS_IDLE;
      end
      default: next_st.hs = HS_IDLE;
    endcase
    if (timeout) begin
      next_st.hs = HS_IDLE;
      next_st.doe = 1'b0;
      next_st.wdr = 1'b0;
    end
    // Receive pacing: count or timer expiry raises the event
    next_st.rx_tim_cnt = (st.rx_pend == 8'h0) ? 16'h0 :
                         (tick_p ? st.rx_tim_cnt + 16'h1 : st.rx_tim_cnt);
    if (rx_packet_done) begin
      next_st.rx_pend = st.rx_pend + 8'h1;
      next_st.tally = st.tally + 8'h1;
    end
    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    next_st.bvalid = st.bvalid && !s_axi_bready;
    next_st.rvalid = st.rvalid && !s_axi_rready;
    next_st.arready = 1'b0;
    if (s_axi_awvalid && !st.aw_seen && !st.bvalid) begin
      next_st.aw_seen = 1'b1;
      next_st.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st.w_seen && !st.bvalid) begin
      next_st.w_seen = 1'b1;
      next_st.w_data = s_axi_wdata;
    end
    if (st.aw_seen && st.w_seen) begin
      next_st.aw_seen = 1'b0;
      next_st.w_seen = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      case (st.aw_addr)
        OFS_CONFIG_REG_FIFTY: next_st.cfg = st.w_data;
        OFS_IRQ_STATUS:       next_st.status = st.status & ~st.w_data[IRQ_BITS-1:0];
        OFS_IRQ_MASK:         next_st.mask = st.w_data[IRQ_BITS-1:0];
        OFS_BUS_WATCH_TIMER:  next_st.watch_lim = st.w_data[15:0];
        OFS_RX_IRQ_TIMER:     next_st.rx_tim_lim = st.w_data[15:0];
        OFS_RX_IRQ_COUNT:     next_st.rx_cnt_lim = st.w_data[7:0];
        OFS_RX_TALLY:         next_st.tally = next_st.tally - st.w_data[7:0];
        default:              next_st.bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !st.rvalid && !st.arready) begin
      next_st.arready = 1'b1;
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case (s_axi_araddr[7:0])
        OFS_CONFIG_REG_FIFTY: next_st.rdata = st.cfg;
        OFS_IRQ_STATUS:       next_st.rdata = 32'(st.status);
        OFS_IRQ_MASK:         next_st.rdata = 32'(st.mask);
        OFS_BUS_WATCH_TIMER:  next_st.rdata = 32'(st.watch_lim);
        OFS_RX_IRQ_TIMER:     next_st.rdata = 32'(st.rx_tim_lim);
        OFS_RX_IRQ_COUNT:     next_st.rdata = 32'(st.rx_cnt_lim);
        OFS_RX_TALLY:         next_st.rdata = 32'(st.tally);
        OFS_PORT_STATUS:      next_st.rdata = {22'h0, st.mii, st.fill, st.hs, st.breq};
        OFS_CACHE_DATA:       next_st.rdata = st.cache[0];
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    if ((st.rx_pend != 8'h0) && (st.rx_pend >= st.rx_cnt_lim ||
        (st.rx_tim_lim != 16'h0 && st.rx_tim_cnt >= st.rx_tim_lim))) begin
      next_st.status[IRQ_RX] = 1'b1;
      next_st.rx_pend = 8'h0;
    end
    if (timeout) next_st.status[IRQ_BUS_ABORT] = 1'b1;
    if (st.hs == HS_WRITE && !st.wdr) next_st.status[IRQ_WRITE_DONE] = 1'b1;
    next_st.irq = |(next_st.status & next_st.mask);
    next_st.awrdy = !next_st.aw_seen && !next_st.bvalid;
    next_st.wrdy  = !next_st.w_seen && !next_st.bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.rd_s <= 3'h7;
      st.wr_s <= 3'h7;
      st.cs_s <= 3'h7;
      st.ack_s <= 3'h7;
      st.awrdy <= 1'b1;
      st.wrdy <= 1'b1;
      st.hs <= HS_IDLE;
      st.breq <= 1'b1;
      st.cfg <= CFG_RESET;
      st.watch_lim <= WATCH_RESET;
      st.rx_tim_lim <= RX_TIMER_RESET;
      st.rx_cnt_lim <= RX_COUNT_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready     = st.awrdy;
  assign s_axi_wready      = st.wrdy;
  assign s_axi_bvalid      = st.bvalid;
  assign s_axi_bresp       = st.bresp;
  assign s_axi_arready     = st.arready;
  assign s_axi_rvalid      = st.rvalid;
  assign s_axi_rdata       = st.rdata;
  assign s_axi_rresp       = st.rresp;
  assign host_data_out     = st.dout;
  assign host_data_oe      = st.doe;
  assign write_done_ready  = st.wdr;
  assign burst_request_n   = st.breq;
  assign irq_out_n         = 1'b0;
  assign irq_out_oe        = st.irq;
  assign mii_rx            = st.mii;
  assign sram_grant        = grant_w;
  assign host_write_word   = st.wword;
  assign host_write_strobe = st.wstb;

  wdr_after_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(write_done_ready) |-> $past(host_write_strobe))
    else $error("ready without captured data");
  no_drive_cs_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.cs_s[2:1] == 2'b11) |=> !host_data_oe) else $error("driving while deselected");
  mii_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.cfg[CFG_MII_MODE] && st.a_s2 == st.a_s3) |=> (mii_rx == $past(st.a_s3)))
    else $error("mii path broken");
  abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.hs != HS_IDLE && st.watch_cnt >= st.watch_lim) |=> (st.hs == HS_IDLE))
    else $error("access not aborted");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    |(st.status & st.mask) |-> irq_out_oe) else $error("irq missing");
  rx_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (st.rx_pend != 8'h0 && st.rx_pend >= st.rx_cnt_lim) |=> st.status[IRQ_RX])
    else $error("rx pacing irq missing");
  req_cache_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !burst_request_n |-> (st.fill != 3'h0)) else $error("request with empty cache");
  width16_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (host_data_oe && host_width_select && $stable(host_width_select))
    |-> (host_data_out[31:16] == 16'h0)) else $error("upper half driven in 16 bit");

endmodule : hbp_host_port

// file: test/hbp_host_model.sv
// Host processor model on the asynchronous host bus pins
module hbp_host_model (
  input  wire logic        aclk,
  input  wire logic        write_done_ready,
  input  wire logic        host_data_oe,
  input  wire logic [31:0] host_data_out,
  output logic             chip_select_n,
  output logic             host_rd_n,
  output logic             host_wr_n,
  output logic             burst_ack_n,
  output logic      [15:1] host_addr,
  output logic      [31:0] host_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chip_select_n = 1'b1;
    host_rd_n     = 1'b1;
    host_wr_n     = 1'b1;
    burst_ack_n   = 1'b1;
    host_addr     = '0;
    host_data_in  = 32'h0;
  end
  task automatic set_addr(input logic [15:1] a);
    @(posedge aclk);
    host_addr <= a;
  endtask : set_addr
  // Ends on ready or after 40 cycles, so a refused write shows as ok low
  task automatic write(input logic [15:1] a, input logic [31:0] d, input logic cs_n,
                       output logic ok);
    int n;
    @(posedge aclk);
    chip_select_n <= cs_n;
    host_addr     <= a;
    host_data_in  <= d;
    host_wr_n     <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (write_done_ready !== 1'b1 && n < 40);
    ok = (write_done_ready === 1'b1);
    chip_select_n <= 1'b1;
    host_wr_n     <= 1'b1;
    host_data_in  <= ~d;   // Released bus keeps no stale copy
    repeat (6) @(posedge aclk);
  endtask : write
  // Ack held low through the whole beat in DMA mode
  task automatic read(input logic [15:1] a, input logic dma, input int hold,
                      output logic [31:0] d);
    int n;
    @(posedge aclk);
    chip_select_n <= 1'b0;
    host_addr     <= a;
    host_rd_n     <= 1'b0;
    burst_ack_n   <= ~dma;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (host_data_oe !== 1'b1 && n < hold);
    d = (host_data_oe === 1'b1) ? host_data_out : 32'hdead_0000;
    chip_select_n <= 1'b1;
    host_rd_n     <= 1'b1;
    burst_ack_n   <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask : read
endmodule : hbp_host_model

// file: test/tb.sv
// Self-checking bench for the host bus port
module tb;
  import hbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, host_width_select, chip_select_n, host_rd_n, host_wr_n;
  logic        host_data_oe, write_done_ready, burst_request_n, burst_ack_n, irq_out_n;
  logic        irq_out_oe, rx_packet_done, rx_buffer_valid, tx_dma_req, rx_dma_req;
  logic        host_write_strobe;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, host_data_in;
  logic [31:0] host_data_out, rx_buffer_word, host_write_word;
  logic [15:1] host_addr;
  logic [3:0]  s_axi_wstrb, mii_rx;
  logic [2:0]  sram_grant;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          n_mismatch, tests_run;
  hbp_host_port u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_width_select, .chip_select_n,
    .host_rd_n, .host_wr_n, .host_addr, .host_data_in, .host_data_out, .host_data_oe,
    .write_done_ready, .burst_request_n, .burst_ack_n, .irq_out_n, .irq_out_oe, .mii_rx,
    .rx_packet_done, .rx_buffer_word, .rx_buffer_valid, .tx_dma_req, .rx_dma_req,
    .sram_grant, .host_write_word, .host_write_strobe
  );
  hbp_host_model u_host (
    .aclk, .write_done_ready, .host_data_oe, .host_data_out, .chip_select_n,
    .host_rd_n, .host_wr_n, .burst_ack_n, .host_addr, .host_data_in
  );
  // ----------------------------------------------------------------
  // Clock and common tasks
  // ----------------------------------------------------------------
  initial aclk = 1'b0;
  always #25 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= {24'h0, a};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d & m, e);
  endtask : rchk
  task automatic fill(input logic [31:0] w);
    @(posedge aclk);
    rx_buffer_word  <= w;
    rx_buffer_valid <= 1'b1;
    @(posedge aclk);
    rx_buffer_valid <= 1'b0;
  endtask : fill
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    test_done();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  g;
    logic        ok, oe0;
    int          n;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, host_width_select, rx_packet_done, rx_buffer_valid} = '0;
    {tx_dma_req, rx_dma_req} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, rx_buffer_word} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(burst_request_n), 32'h1);
    chk(32'(host_data_oe), 32'h0);
    rchk(OFS_CONFIG_REG_FIFTY, 32'hffff_ffff, 32'h0);
    rchk(OFS_BUS_WATCH_TIMER, 32'hffff, 32'h00ff);
    rchk(OFS_RX_IRQ_COUNT, 32'hff, 32'h01);
    rchk(OFS_RX_IRQ_TIMER, 32'hffff, 32'h0);
    axi_rd(8'h40, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    u_host.write(15'h0004, 32'h1234_5678, 1'b0, ok);
    chk(32'(ok), 32'h1);
    chk(host_write_word, 32'h1234_5678);
    rchk(OFS_IRQ_STATUS, 32'h4, 32'h4);
    // Mask polarity left open: only a change of the pin is required
    axi_wr(OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge aclk);
    oe0 = irq_out_oe;
    axi_wr(OFS_IRQ_MASK, 32'h7);
    repeat (3) @(posedge aclk);
    chk(32'(oe0 ^ irq_out_oe), 32'h1);
    chk(32'(irq_out_n), 32'h0);
    axi_wr(OFS_IRQ_STATUS, 32'h7);
    repeat (3) @(posedge aclk);
    chk(32'(irq_out_oe), 32'h0);
    rchk(OFS_IRQ_STATUS, 32'h7, 32'h0);
    host_width_select <= 1'b1;
    u_host.write(15'h0004, 32'haaaa_5555, 1'b0, ok);
    chk(host_write_word, 32'h0000_5555);
    host_width_select <= 1'b0;
    u_host.write(15'h0004, 32'h0f0f_0f0f, 1'b1, ok);
    chk(32'(ok), 32'h0);
    chk(host_write_word, 32'h0000_5555);
    u_host.write(15'h0104, 32'h0000_0202, 1'b0, ok);
    chk(host_write_word, 32'h0000_0202);
    axi_wr(OFS_CONFIG_REG_FIFTY, 32'h40);
    u_host.write(15'h0104, 32'h0000_0303, 1'b0, ok);
    chk(32'(ok), 32'h0);
    axi_wr(OFS_CONFIG_REG_FIFTY, 32'h1);
    for (int i = 2; i >= 0; i--) begin
      u_host.set_addr(15'({4'(4'ha >> i), 7'h0}));
      repeat (8) @(posedge aclk);
      chk(32'(mii_rx), 32'(4'(4'ha >> i)));
    end
    axi_wr(OFS_CONFIG_REG_FIFTY, 32'h0);
    u_host.set_addr(15'h0);
    tx_dma_req <= 1'b1;
    rx_dma_req <= 1'b1;
    g = 3'h0;
    repeat (12) begin
      @(posedge aclk);
      g = g | sram_grant;
      if ($countones(sram_grant) > 1) chk(32'(sram_grant), 32'h0);
    end
    chk(32'(g[2:1]), 32'h3);
    tx_dma_req <= 1'b0;
    rx_dma_req <= 1'b0;
    rx_packet_done <= 1'b1;
    @(posedge aclk);
    rx_packet_done <= 1'b0;
    repeat (4) @(posedge aclk);
    rchk(OFS_IRQ_STATUS, 32'h1, 32'h1);
    rchk(OFS_RX_TALLY, 32'hff, 32'h1);
    fill(32'hcafe_0001);
    u_host.read(15'h0, 1'b0, 30, d);
    chk(d, 32'hcafe_0001);
    host_width_select <= 1'b1;
    fill(32'h7777_1357);
    u_host.read(15'h0, 1'b0, 30, d);
    chk(d, 32'h0000_1357);
    host_width_select <= 1'b0;
    axi_wr(OFS_CONFIG_REG_FIFTY, 32'h6);
    fill(32'hbeef_0002);
    fill(32'hbeef_0003);
    n = 0;
    while (burst_request_n !== 1'b0 && n < 30) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(burst_request_n), 32'h0);
    u_host.read(15'h0, 1'b1, 30, d);
    chk(d, 32'hbeef_0002);
    u_host.read(15'h0, 1'b1, 30, d);
    chk(d, 32'hbeef_0003);
    chk(32'(burst_request_n), 32'h1);
    axi_wr(OFS_CONFIG_REG_FIFTY, 32'h0);
    axi_wr(OFS_BUS_WATCH_TIMER, 32'h0);
    fill(32'h5a5a_0004);
    u_host.read(15'h0, 1'b0, 80, d);
    chk(d, 32'hdead_0000);
    rchk(OFS_IRQ_STATUS, 32'h2, 32'h2);
    test_done();
  end
endmodule : tb
